// file: logic/pmic_irq_pkg.sv
// Constants, register map and carrier types of the interrupt and pin block.
//
// Summary of operation
// - Event bit latches until software clears it.
// - Writing one clears only those event bits.
// - Reading event registers never clears anything.
// - Primary interrupt ORs its unmasked event bits.
// - Per-event mask; masked events still latch.
// - Request pin high while enabled event pending.
// - Twelve pins, direction chosen per pin.
// - Per-pin polarity for input and output.
// - Per-pin pull none, up or down.
// - Output drive push-pull or open-drain.
// - Tri-state setting leaves pin undriven.
// - Input pins raise their own latched event bits.
// - Alternate input functions drive control requests.
// - Alternate outputs: state, 32kHz, scaling, power-good.
// - Per-pin supply domain bit, resets default.
package pmic_irq_pkg;

    localparam int PIN_COUNT = 12;
    localparam int SYS_COUNT = 8;
    localparam int PRIM_COUNT = 2;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register indices.
    localparam logic [7:0] PRIMARY_STATUS_ADDR = 8'h00;
    localparam logic [7:0] PRIMARY_MASK_ADDR = 8'h01;
    localparam logic [7:0] GPIO_EVENT_ADDR = 8'h02;
    localparam logic [7:0] GPIO_EVENT_MASK_ADDR = 8'h03;
    localparam logic [7:0] SYS_EVENT_ADDR = 8'h04;
    localparam logic [7:0] SYS_EVENT_MASK_ADDR = 8'h05;
    localparam logic [7:0] GPIO_LEVEL_ADDR = 8'h06;
    localparam logic [7:0] GPIO_DATA_ADDR = 8'h07;
    localparam logic [3:0] GPIO_CFG_PAGE = 4'h1;

    // Primary interrupt bit positions.
    localparam int PRIM_GPIO_BIT = 0;
    localparam int PRIM_SYS_BIT = 1;

    // Reset values: every source masked, pins idle.
    localparam logic [1:0] PRIMARY_MASK_RESET = 2'h3;
    localparam logic [11:0] GPIO_MASK_RESET = 12'hFFF;
    localparam logic [7:0] SYS_MASK_RESET = 8'hFF;
    localparam logic [15:0] GPIO_CFG_RESET = 16'h0400;

    // Pull selections.
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;

    // Pin function codes.
    localparam logic [3:0] FUNC_GPIO = 4'h0;
    localparam logic [3:0] FUNC_POWER_REQ = 4'h1;
    localparam logic [3:0] FUNC_SCALING_REQ = 4'h2;
    localparam logic [3:0] FUNC_MODE_CTRL = 4'h3;
    localparam logic [3:0] FUNC_POWER_IND = 4'h8;
    localparam logic [3:0] FUNC_CLK32K = 4'h9;
    localparam logic [3:0] FUNC_SCALING_DONE = 4'hA;
    localparam logic [3:0] FUNC_SYS_PGOOD = 4'hB;
    localparam logic [3:0] FUNC_CONV_PGOOD = 4'hC;

    // Timing of the 32kHz output derived from the 100 MHz clock.
    localparam int MCLK_HZ = 100_000_000;
    localparam int CLK32K_HZ = 32_768;
    localparam int CLK32K_HALF_CYC = MCLK_HZ / (2 * CLK32K_HZ);
    localparam logic [11:0] CLK32K_HALF_LAST = 12'(CLK32K_HALF_CYC - 1);

    // Per-pin configuration word, one register per pin.
    typedef struct packed {
        logic dir_out;
        logic active_low;
        logic [1:0] pull;
        logic open_drain;
        logic tristate;
        logic alt_domain;
        logic int_en;
        logic [3:0] reserved;
        logic [3:0] func;
    } gpio_cfg_type;

    // Register port request from software.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

// file: logic/pmic_irq_gpio.sv
// Two-level interrupt logic with twelve configurable general-purpose pins.
module pmic_irq_gpio
    import pmic_irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_type req,
    output logic [DATA_W-1:0] rdata,
    input wire logic [PIN_COUNT-1:0] gpio_in,
    output logic [PIN_COUNT-1:0] gpio_out,
    output logic [PIN_COUNT-1:0] gpio_oe,
    output logic [PIN_COUNT-1:0] pull_up_en,
    output logic [PIN_COUNT-1:0] pull_down_en,
    output logic [PIN_COUNT-1:0] alt_domain_sel,
    input wire logic [SYS_COUNT-1:0] sys_event_in,
    input wire logic power_state_ind,
    input wire logic dynamic_voltage_scaling_done,
    input wire logic sys_pgood,
    input wire logic conv_pgood,
    output logic power_state_req,
    output logic dynamic_voltage_scaling_req,
    output logic reg_mode_ctrl,
    output logic irq
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic func_is(gpio_cfg_type c, logic [3:0] code);
        return c.func == code;
    endfunction

    function automatic logic cfg_hit(logic [ADDR_W-1:0] a);
        return a[7:4] == GPIO_CFG_PAGE && a[3:0] < 4'(PIN_COUNT);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    gpio_cfg_type cfg_r [PIN_COUNT];
    logic [1:0] primary_mask_r;
    logic [PIN_COUNT-1:0] gpio_event_r;
    logic [PIN_COUNT-1:0] gpio_event_nxt;
    logic [PIN_COUNT-1:0] gpio_mask_r;
    logic [SYS_COUNT-1:0] sys_event_r;
    logic [SYS_COUNT-1:0] sys_event_nxt;
    logic [SYS_COUNT-1:0] sys_mask_r;
    logic [PIN_COUNT-1:0] gpio_data_r;
    logic [PIN_COUNT-1:0] sync1_r;
    logic [PIN_COUNT-1:0] sync2_r;
    logic [PIN_COUNT-1:0] level_r;
    logic [PIN_COUNT-1:0] level_nxt;
    logic [PIN_COUNT-1:0] pin_set;
    logic [PIN_COUNT-1:0] out_nxt;
    logic [PIN_COUNT-1:0] oe_nxt;
    logic [PIN_COUNT-1:0] pu_nxt;
    logic [PIN_COUNT-1:0] pd_nxt;
    logic [PIN_COUNT-1:0] dom_nxt;
    logic [PIN_COUNT-1:0] preq_vec;
    logic [PIN_COUNT-1:0] scaling_vec;
    logic [PIN_COUNT-1:0] mode_vec;
    logic [1:0] primary;
    logic [11:0] div_r;
    logic clk32k_r;
    logic [DATA_W-1:0] rdata_r;
    logic irq_r;
    logic [3:0] cfg_idx;

    assign cfg_idx = req.addr[3:0];

    // ------------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------------
    // The first stage feeds only the second, so a metastable sample never
    // reaches the edge detector.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            level_r <= '0;
        end else begin
            sync1_r <= gpio_in;
            sync2_r <= sync1_r;
            level_r <= level_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Per-pin logic
    // ------------------------------------------------------------------
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        logic drive_val;
        logic asserted;
        always_comb begin
            // Asserted level after polarity.
            level_nxt[i] = sync2_r[i] ^ cfg_r[i].active_low;
            // Event on the asserted edge of an input pin.
            pin_set[i] = cfg_r[i].int_en && !cfg_r[i].dir_out
                && level_nxt[i] && !level_r[i];
            case (cfg_r[i].func)
                FUNC_POWER_IND: asserted = power_state_ind;
                FUNC_CLK32K: asserted = clk32k_r;
                FUNC_SCALING_DONE: begin
                    asserted = dynamic_voltage_scaling_done;
                end
                FUNC_SYS_PGOOD: asserted = sys_pgood;
                FUNC_CONV_PGOOD: asserted = conv_pgood;
                default: asserted = gpio_data_r[i];
            endcase
            drive_val = asserted ^ cfg_r[i].active_low;
            if (!cfg_r[i].dir_out || cfg_r[i].tristate) begin
                out_nxt[i] = 1'b0;
                oe_nxt[i] = 1'b0;
            end else if (cfg_r[i].open_drain) begin
                out_nxt[i] = 1'b0;
                oe_nxt[i] = !drive_val;
            end else begin
                out_nxt[i] = drive_val;
                oe_nxt[i] = 1'b1;
            end
            pu_nxt[i] = cfg_r[i].pull == PULL_UP;
            pd_nxt[i] = cfg_r[i].pull == PULL_DOWN;
            dom_nxt[i] = cfg_r[i].alt_domain;
            // Alternate input functions only listen to input pins.
            preq_vec[i] = !cfg_r[i].dir_out
                && func_is(cfg_r[i], FUNC_POWER_REQ) && level_nxt[i];
            scaling_vec[i] = !cfg_r[i].dir_out
                && func_is(cfg_r[i], FUNC_SCALING_REQ)
                && level_nxt[i];
            mode_vec[i] = !cfg_r[i].dir_out
                && func_is(cfg_r[i], FUNC_MODE_CTRL) && level_nxt[i];
        end

        a_pull_select: assert property (
            @(posedge mclk) disable iff (rst)
            cfg_r[i].pull == PULL_UP |=> pull_up_en[i] && !pull_down_en[i])
            else $error("Pull-up selection not applied.");
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gpio_out <= '0;
            gpio_oe <= '0;
            pull_up_en <= '0;
            pull_down_en <= '0;
            alt_domain_sel <= '0;
            power_state_req <= 1'b0;
            dynamic_voltage_scaling_req <= 1'b0;
            reg_mode_ctrl <= 1'b0;
        end else begin
            gpio_out <= out_nxt;
            gpio_oe <= oe_nxt;
            pull_up_en <= pu_nxt;
            pull_down_en <= pd_nxt;
            alt_domain_sel <= dom_nxt;
            power_state_req <= |preq_vec;
            dynamic_voltage_scaling_req <= |scaling_vec;
            reg_mode_ctrl <= |mode_vec;
        end
    end

    // ------------------------------------------------------------------
    // 32kHz divider
    // ------------------------------------------------------------------
    // Integer division leaves the output slightly fast; a low-frequency
    // reference, not a timing-accurate crystal replacement.
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= '0;
            clk32k_r <= 1'b0;
        end else if (div_r == CLK32K_HALF_LAST) begin
            div_r <= '0;
            clk32k_r <= !clk32k_r;
        end else begin
            div_r <= div_r + 12'h001;
        end
    end

    // ------------------------------------------------------------------
    // Secondary events
    // ------------------------------------------------------------------
    always_comb begin
        gpio_event_nxt = gpio_event_r;
        sys_event_nxt = sys_event_r;
        if (req.wr && req.addr == GPIO_EVENT_ADDR) begin
            gpio_event_nxt = gpio_event_r
                & ~req.wdata[PIN_COUNT-1:0];
        end
        if (req.wr && req.addr == SYS_EVENT_ADDR) begin
            sys_event_nxt = sys_event_r
                & ~req.wdata[SYS_COUNT-1:0];
        end
        // Setting after clearing lets a fresh event win the cycle.
        gpio_event_nxt = gpio_event_nxt | pin_set;
        sys_event_nxt = sys_event_nxt | sys_event_in;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gpio_event_r <= '0;
            sys_event_r <= '0;
        end else begin
            gpio_event_r <= gpio_event_nxt;
            sys_event_r <= sys_event_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            primary_mask_r <= PRIMARY_MASK_RESET;
            gpio_mask_r <= GPIO_MASK_RESET;
            sys_mask_r <= SYS_MASK_RESET;
            gpio_data_r <= '0;
            for (int n = 0; n < PIN_COUNT; n++) begin
                cfg_r[n] <= GPIO_CFG_RESET;
            end
        end else if (req.wr) begin
            case (req.addr)
                PRIMARY_MASK_ADDR: primary_mask_r <= req.wdata[1:0];
                GPIO_EVENT_MASK_ADDR: begin
                    gpio_mask_r <= req.wdata[PIN_COUNT-1:0];
                end
                SYS_EVENT_MASK_ADDR: begin
                    sys_mask_r <= req.wdata[SYS_COUNT-1:0];
                end
                GPIO_DATA_ADDR: gpio_data_r <= req.wdata[PIN_COUNT-1:0];
                default: begin
                    if (cfg_hit(req.addr)) begin
                        cfg_r[cfg_idx] <= req.wdata;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Primary interrupts and request pin
    // ------------------------------------------------------------------
    always_comb begin
        primary[PRIM_GPIO_BIT] = |(gpio_event_r & ~gpio_mask_r);
        primary[PRIM_SYS_BIT] = |(sys_event_r & ~sys_mask_r);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(primary & ~primary_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Reads are pure: nothing below touches the event registers.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (req.rd) begin
            rdata_r <= '0;
            case (req.addr)
                PRIMARY_STATUS_ADDR: rdata_r[1:0] <= primary;
                PRIMARY_MASK_ADDR: rdata_r[1:0] <= primary_mask_r;
                GPIO_EVENT_ADDR: begin
                    rdata_r[PIN_COUNT-1:0] <= gpio_event_r;
                end
                GPIO_EVENT_MASK_ADDR: rdata_r[PIN_COUNT-1:0] <= gpio_mask_r;
                SYS_EVENT_ADDR: begin
                    rdata_r[SYS_COUNT-1:0] <= sys_event_r;
                end
                SYS_EVENT_MASK_ADDR: rdata_r[SYS_COUNT-1:0] <= sys_mask_r;
                GPIO_LEVEL_ADDR: rdata_r[PIN_COUNT-1:0] <= level_r;
                GPIO_DATA_ADDR: rdata_r[PIN_COUNT-1:0] <= gpio_data_r;
                default: begin
                    if (cfg_hit(req.addr)) begin
                        rdata_r <= cfg_r[cfg_idx];
                    end
                end
            endcase
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_event_sticky: assert property (
        @(posedge mclk) disable iff (rst)
        $past(gpio_event_r[0]) && !($past(req.wr)
            && $past(req.addr) == GPIO_EVENT_ADDR && $past(req.wdata[0]))
        |-> gpio_event_r[0])
        else $error("Event bit dropped without a clear.");

    // A fresh event in the clearing cycle may legally set a zero-written bit.
    a_clear_only_ones: assert property (
        @(posedge mclk) disable iff (rst)
        req.wr && req.addr == SYS_EVENT_ADDR
        |=> ((sys_event_r & $past(~req.wdata[SYS_COUNT-1:0]))
            == (($past(sys_event_r) | $past(sys_event_in))
            & $past(~req.wdata[SYS_COUNT-1:0]))))
        else $error("Clear touched a bit written as zero.");

    a_gpio_w1c: assert property (
        @(posedge mclk) disable iff (rst)
        req.wr && req.addr == GPIO_EVENT_ADDR && req.wdata[5] && !pin_set[5]
        |=> !gpio_event_r[5])
        else $error("Pin event survived a clear.");

    a_read_no_clear: assert property (
        @(posedge mclk) disable iff (rst)
        req.rd && !req.wr |=> sys_event_r == ($past(sys_event_r)
            | $past(sys_event_in)))
        else $error("Read altered latched events.");

    a_masked_latch: assert property (
        @(posedge mclk) disable iff (rst)
        sys_event_in[0] && sys_mask_r[0] |=> sys_event_r[0])
        else $error("Masked event failed to latch.");

    a_primary_or: assert property (
        @(posedge mclk) disable iff (rst)
        primary[PRIM_SYS_BIT] == |(sys_event_r & ~sys_mask_r))
        else $error("Primary does not follow unmasked events.");

    a_irq_follows: assert property (
        @(posedge mclk) disable iff (rst)
        ##1 irq == $past(|(primary & ~primary_mask_r)))
        else $error("Request pin wrong one cycle after cause.");

    a_set_wins: assert property (
        @(posedge mclk) disable iff (rst)
        sys_event_in[1] && req.wr && req.addr == SYS_EVENT_ADDR
        && req.wdata[1] |=> sys_event_r[1])
        else $error("Event lost against a clear.");

    a_tristate_quiet: assert property (
        @(posedge mclk) disable iff (rst)
        cfg_r[0].tristate |=> !gpio_oe[0])
        else $error("Tri-stated pin driven.");

    a_open_drain_low: assert property (
        @(posedge mclk) disable iff (rst)
        gpio_oe[1] && $past(cfg_r[1].open_drain) |-> !gpio_out[1])
        else $error("Open-drain pin drove high.");

    a_domain_follow: assert property (
        @(posedge mclk) disable iff (rst)
        alt_domain_sel[5] == $past(cfg_r[5].alt_domain))
        else $error("Supply domain select does not follow its bit.");

    a_pin_edge: assert property (
        @(posedge mclk) disable iff (rst)
        cfg_r[2].int_en && !cfg_r[2].dir_out && !cfg_r[2].active_low
        && !level_r[2] && sync2_r[2] |=> gpio_event_r[2])
        else $error("Asserted pin edge did not raise its event.");

endmodule

// file: verification/irq_host_model.sv
// Host processor model that services the interrupt request pin.
module irq_host_model
    import pmic_irq_pkg::*;
(
    input wire logic mclk,
    input wire logic en,
    input wire logic [2:0] lag,
    input wire logic irq,
    input wire logic [DATA_W-1:0] rdata,
    output reg_req_type req
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [DATA_W-1:0] seen;

    // Reads one event register, then clears exactly what it saw.
    task automatic service(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '0;
        @(negedge mclk);
        seen = rdata;
        if (seen !== 16'h0000) begin
            @(posedge mclk);
            req <= '{a, seen, 1'b1, 1'b0};
            @(posedge mclk);
            req <= '0;
        end
    endtask

    initial begin
        req = '0;
        forever begin
            @(posedge mclk);
            if (en && irq === 1'b1) begin
                // A slow host leaves the request pending for a while.
                repeat (lag) @(posedge mclk);
                service(GPIO_EVENT_ADDR);
                service(SYS_EVENT_ADDR);
            end
        end
    end
endmodule

// file: verification/pmic_irq_gpio_tb.sv
// Self-checking bench for the interrupt and pin block.
module pmic_irq_gpio_tb
    import pmic_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic host_en = 1'b0;
    logic [2:0] host_lag = 3'h0;
    reg_req_type tb_req = '0;
    reg_req_type host_req;
    reg_req_type req;
    logic [DATA_W-1:0] rdata;
    logic [PIN_COUNT-1:0] gpio_in = '0;
    logic [PIN_COUNT-1:0] gpio_out, gpio_oe, pull_up_en, pull_down_en;
    logic [PIN_COUNT-1:0] alt_domain_sel;
    logic [SYS_COUNT-1:0] sys_event_in = '0;
    logic [3:0] srcs = 4'h0;
    logic power_state_req, dynamic_voltage_scaling_req, reg_mode_ctrl, irq;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 59;
    logic [15:0] ev, m, c, d, v;
    gpio_cfg_type g;
    logic [1:0] e;
    int n, t;
    logic al;

    always #5 mclk = ~mclk;
    assign req = host_en ? host_req : tb_req;

    pmic_irq_gpio pmic_irq_gpio_inst (.mclk(mclk), .rst(rst), .req(req),
        .rdata(rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .alt_domain_sel(alt_domain_sel),
        .sys_event_in(sys_event_in), .power_state_ind(srcs[3]),
        .dynamic_voltage_scaling_done(srcs[2]), .sys_pgood(srcs[1]),
        .conv_pgood(srcs[0]),
        .power_state_req(power_state_req),
        .dynamic_voltage_scaling_req(dynamic_voltage_scaling_req),
        .reg_mode_ctrl(reg_mode_ctrl), .irq(irq));

    irq_host_model irq_host_model_inst (.mclk(mclk), .en(host_en),
        .lag(host_lag), .irq(irq), .rdata(rdata), .req(host_req));

    // Expected {oe, out} of an output pin; out only matters while oe.
    function automatic logic [1:0] pin_exp(input gpio_cfg_type cfg,
                                           input logic dat);
        logic lvl;
        lvl = dat ^ cfg.active_low;
        if (cfg.tristate) return 2'b00;
        if (cfg.open_drain) return {!lvl, 1'b0};
        return {1'b1, lvl};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] dat);
        @(posedge mclk);
        tb_req <= '{a, dat, 1'b1, 1'b0};
        @(posedge mclk);
        tb_req <= '0;
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [15:0] exp);
        @(posedge mclk);
        tb_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        tb_req <= '0;
        @(negedge mclk);
        check(what, rdata, exp);
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        $display("Error watchdog expected finish seen hang");
        test_done;
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        step(1);
        check("oe", 16'(gpio_oe), 16'h0000);
        check("domain", 16'(alt_domain_sel), 16'h0000);
        rdc("pmask", PRIMARY_MASK_ADDR, 16'h0003);
        rdc("gmask", GPIO_EVENT_MASK_ADDR, 16'h0FFF);
        rdc("smask", SYS_EVENT_MASK_ADDR, 16'h00FF);
        rdc("cfg", {GPIO_CFG_PAGE, 4'h0}, GPIO_CFG_RESET);
        wr(8'h08, 16'hFFFF);
        rdc("unmapped", 8'h08, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            ev = 16'($random(seed) & 8'hFF);
            m = (i == 0) ? 16'h00FF : 16'($random(seed) & 8'hFF);
            c = 16'($random(seed));
            wr(SYS_EVENT_MASK_ADDR, m);
            wr(PRIMARY_MASK_ADDR, {14'h0, i[0], 1'b0});
            @(posedge mclk);
            sys_event_in <= ev[7:0];
            @(posedge mclk);
            sys_event_in <= '0;
            rdc("sys ev", SYS_EVENT_ADDR, ev);
            rdc("sys ev again", SYS_EVENT_ADDR, ev);
            rdc("status", PRIMARY_STATUS_ADDR,
                {14'h0, |(ev & ~m), 1'b0});
            check("irq", 16'(irq), 16'(|(ev & ~m) & !i[0]));
            wr(SYS_EVENT_ADDR, c);
            rdc("w1c", SYS_EVENT_ADDR, ev & ~c & 16'h00FF);
            wr(SYS_EVENT_ADDR, 16'h00FF);
            rdc("status clr", PRIMARY_STATUS_ADDR, 16'h0000);
        end
        fork
            wr(SYS_EVENT_ADDR, 16'h0003);
            begin
                @(posedge mclk);
                sys_event_in <= 8'h03;
                @(posedge mclk);
                sys_event_in <= '0;
            end
        join
        rdc("set wins", SYS_EVENT_ADDR, 16'h0003);
        wr(SYS_EVENT_ADDR, 16'h00FF);
        $display("test events done");
        for (int r = 0; r < 3; r++) begin
            d = 16'($random(seed));
            wr(GPIO_DATA_ADDR, d);
            for (int p = 0; p < PIN_COUNT; p++) begin
                g = gpio_cfg_type'(16'($random(seed)));
                g.dir_out = 1'b1;
                g.int_en = 1'b0;
                g.func = FUNC_GPIO;
                if (g.pull == 2'h3) g.pull = PULL_NONE;
                wr({GPIO_CFG_PAGE, 4'(p)}, g);
                step(1);
                e = pin_exp(g, d[p]);
                check("oe", 16'(gpio_oe[p]), 16'(e[1]));
                if (e[1]) check("out", 16'(gpio_out[p]), 16'(e[0]));
                check("pu", 16'(pull_up_en[p]), 16'(g.pull == PULL_UP));
                check("pd", 16'(pull_down_en[p]), 16'(g.pull == PULL_DOWN));
                check("dom", 16'(alt_domain_sel[p]), 16'(g.alt_domain));
            end
        end
        $display("test pin outputs done");
        wr(PRIMARY_MASK_ADDR, 16'h0000);
        // Idle every pin so the level register shows only the pin under test.
        for (int p = 0; p < PIN_COUNT; p++) begin
            wr({GPIO_CFG_PAGE, 4'(p)}, GPIO_CFG_RESET);
        end
        for (int r = 0; r < 4; r++) begin
            // The first round is a fixed corner: pin 2, active high.
            n = (r == 0) ? 2 : {$random(seed)} % PIN_COUNT;
            al = (r == 0) ? 1'b0 : 1'($random(seed));
            @(posedge mclk);
            gpio_in[n] <= al;
            host_lag <= 3'($random(seed));
            wr({GPIO_CFG_PAGE, 4'(n)}, {1'b0, al, 14'h0500});
            wr(GPIO_EVENT_MASK_ADDR, 16'(~(12'h001 << n)));
            step(4);
            wr(GPIO_EVENT_ADDR, 16'h0FFF);
            @(posedge mclk);
            gpio_in[n] <= ~al;
            step(1);
            check("sync", 16'(irq), 16'h0000);
            step(4);
            check("pin irq", 16'(irq), 16'h0001);
            rdc("pin ev", GPIO_EVENT_ADDR, 16'(12'h001 << n));
            rdc("level", GPIO_LEVEL_ADDR, 16'(12'h001 << n));
            @(posedge mclk);
            host_en <= 1'b1;
            t = 0;
            while (irq !== 1'b0 && t < 100) begin
                @(posedge mclk);
                t++;
            end
            step(4);
            host_en <= 1'b0;
            rdc("served", GPIO_EVENT_ADDR, 16'h0000);
            @(posedge mclk);
            gpio_in[n] <= al;
        end
        $display("test pin events done");
        for (int k = 0; k < 3; k++) begin
            wr({GPIO_CFG_PAGE, 4'(k)}, 16'(GPIO_CFG_RESET | (k + 1)));
            @(posedge mclk);
            gpio_in[k] <= 1'b1;
            step(4);
            check("alt in", 16'({power_state_req, dynamic_voltage_scaling_req,
                reg_mode_ctrl}), 16'(3'b100 >> k));
            @(posedge mclk);
            gpio_in[k] <= 1'b0;
        end
        for (int j = 0; j < 8; j++) begin
            c = {12'h0, FUNC_POWER_IND};
            if (j % 4 > 0) c = 16'(FUNC_SCALING_DONE + j % 4 - 1);
            wr(8'h14, 16'h8000 | c);
            @(posedge mclk);
            srcs <= 4'($random(seed));
            step(3);
            check("alt out", 16'(gpio_out[4]), 16'(srcs[3 - j % 4]));
        end
        wr(8'h14, {12'h800, FUNC_CLK32K});
        step(2);
        t = 0;
        for (int i = 0; i < 2 * CLK32K_HALF_CYC + 2; i++) begin
            al = gpio_out[4];
            step(1);
            if (gpio_out[4] !== al) t++;
        end
        check("clk toggles", 16'(t >= 2 && t <= 3), 16'h0001);
        $display("test alt functions done");
        test_done;
    end
endmodule
